// >>> design/rbo_sequencer.sv
/*
  Rod bank overlap sequencer: takes the bank selector, the in/hold/out
  lever and the automatic demand, and issues coil sequence orders per rod
  group with overlap, order, speed and inhibit handling.
  Assumes all inputs are asynchronous to i_clk and that the power cabinets
  drive every mechanism of a group from its single step order line.
*/
// Behaviour
// - One order line steps a whole group.
// - Groups of a bank stay within one step unless reversed while uneven.
// - Withdraw A to D, insert D to A.
// - Next bank joins at overlap position.
// - Leading bank stops at core top.
// - Bank D continues alone after C tops.
// - Overlapped banks step matching groups together.
// - Shutdown banks move manually, never overlapped.
// - Four abnormal conditions block withdrawal.
// - Low turbine power disables automatic mode.
// - Automatic withdrawal halts past bank D limit.
// - Automatic: control banks only, 8 to 72 spm.
// - Manual rates are fixed presets.
// - Each coil sequence lasts 780 ms.
// - Speed set only by idle gap.
// - Lever acts only in manual or bank.
// - In automatic, lever is ignored.
// - Hold lever: selector changes move nothing.
// - Overlap program in automatic and manual.
// - Multiplexing failure blocks new steps; a running one completes.
// - Automatic needs thermal power above 15 percent.
// - No group moves out of sequence.
// - Command change waits for step end.
// - Early step pulse halts, alarms, latches.
`default_nettype none

module rbo_sequencer #(
  parameter int N_CTRL = rbo_pkg::N_CTRL,
  parameter int N_SD = rbo_pkg::N_SD,
  parameter int POS_W = rbo_pkg::POS_W,
  parameter logic [POS_W-1:0] TOP = rbo_pkg::TOP_STEPS,
  parameter logic [POS_W-1:0] OVL = rbo_pkg::OVERLAP_STEPS,
  parameter logic [POS_W-1:0] DLIM = rbo_pkg::D_LIMIT_STEPS,
  parameter int SEQ_CYC = rbo_pkg::SEQ_CYC,
  parameter int MINUTE_CYC = rbo_pkg::MINUTE_CYC,
  parameter logic [6:0] MAN_CTRL_SPM = rbo_pkg::MAN_CTRL_SPM,
  parameter logic [6:0] MAN_SD_SPM = rbo_pkg::MAN_SD_SPM
) (
  input wire logic i_clk, // System clock.
  input wire logic i_reset, // Asynchronous plant reset.
  input wire logic [rbo_pkg::SEL_W-1:0] i_selector, // Bank selector code.
  input wire logic i_lever_in, // Lever in position.
  input wire logic i_lever_out, // Lever out position.
  input wire logic i_auto_in, // Automatic insert demand.
  input wire logic i_auto_out, // Automatic withdraw demand.
  input wire logic [rbo_pkg::SPM_W-1:0] i_auto_spm, // Automatic speed demand.
  input wire logic i_pr_overpower, // Power range overpower.
  input wire logic i_ir_overpower, // Intermediate range overpower.
  input wire logic i_op_delta_t, // Overpower delta-T.
  input wire logic i_ot_delta_t, // Overtemperature delta-T.
  input wire logic i_turbine_ok, // Turbine power at or above 15 percent.
  input wire logic i_thermal_ok, // Thermal power above 15 percent.
  input wire logic i_mux_fail, // Cabinet multiplexing failure.
  input wire logic i_fault_clear, // Clears the overspeed halt.
  output logic [2*(N_CTRL+N_SD)-1:0] o_step_group, // Coil sequence order per group.
  output logic o_dir_out, // Direction of the order, high for out.
  output logic o_busy, // A coil sequence is running.
  output logic o_urgent, // Overspeed halt latched.
  output logic o_auto_active, // Automatic mode in control.
  output logic o_withdraw_block, // Withdrawal inhibited.
  output logic o_cmd_pending, // Command change held off.
  output logic [2*(N_CTRL+N_SD)*POS_W-1:0] o_group_pos // Step count per group.
);

  localparam int NB = N_CTRL + N_SD;
  localparam int NG = 2 * NB;
  localparam int SEQ_W = $clog2(SEQ_CYC + 1);
  localparam int SYN_W = rbo_pkg::SEL_W + rbo_pkg::SPM_W + 12;
  localparam logic [POS_W-1:0] JOIN_IN = TOP - OVL;
  localparam logic [31:0] MIN_ACC = 32'(MINUTE_CYC);
  localparam int CMD_W = rbo_pkg::SEL_W + 2;

  // Two-stage synchronisers for every input pin except i_clk and i_reset.
  logic [SYN_W-1:0] sync1;
  logic [SYN_W-1:0] sync2;
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= {i_selector, i_lever_in, i_lever_out, i_auto_in, i_auto_out, i_auto_spm, i_pr_overpower,
                i_ir_overpower, i_op_delta_t, i_ot_delta_t, i_turbine_ok, i_thermal_ok, i_mux_fail, i_fault_clear};
      sync2 <= sync1;
    end
  end

  logic [rbo_pkg::SEL_W-1:0] sel_s;
  logic lev_in_s, lev_out_s, a_in_s, a_out_s;
  logic [rbo_pkg::SPM_W-1:0] spm_s;
  logic [3:0] inh_s;
  logic turb_s, therm_s, mux_s, clr_s;
  assign {sel_s, lev_in_s, lev_out_s, a_in_s, a_out_s, spm_s, inh_s,
          turb_s, therm_s, mux_s, clr_s} = sync2;

  // Command decode: selector plus requested direction.
  logic auto_sel, auto_ok, raw_out, raw_in;
  logic [CMD_W-1:0] cmd_raw;
  always_comb begin
    auto_sel = (sel_s == rbo_pkg::SEL_AUTO);
    auto_ok = turb_s && therm_s;
    if (auto_sel) begin
      raw_out = auto_ok && a_out_s && !a_in_s;
      raw_in = auto_ok && a_in_s && !a_out_s;
    end else if (int'(sel_s) < int'(rbo_pkg::SEL_BANK0) + NB) begin
      raw_out = lev_out_s && !lev_in_s;
      raw_in = lev_in_s && !lev_out_s;
    end else begin
      raw_out = 1'b0;
      raw_in = 1'b0;
    end
    cmd_raw = {sel_s, raw_out, raw_in};
  end

  // Registered state: command latch, pulser, cycler, group counters.
  rbo_pkg::rbo_cyc_t state, next_state;
  logic [CMD_W-1:0] cmd_q, next_cmd_q;
  logic [31:0] acc, next_acc;
  logic [SEQ_W-1:0] seq_cnt, next_seq_cnt;
  logic [NG-1:0] grp_q, next_grp_q;
  logic dir_q, next_dir_q;
  logic [POS_W-1:0] cnt [NG];
  logic [POS_W-1:0] next_cnt [NG];

  logic [rbo_pkg::SEL_W-1:0] sel_q;
  logic out_q, in_q;
  assign {sel_q, out_q, in_q} = cmd_q;

  // Bank selection from the latched command and the group counters.
  logic [NB-1:0] move;
  logic [NG-1:0] grp;
  always_comb begin
    int lead;
    int c;
    logic found;
    lead = 0;
    c = 0;
    found = 1'b0;
    move = '0;
    if (sel_q == rbo_pkg::SEL_AUTO || sel_q == rbo_pkg::SEL_MANUAL) begin
      if (out_q) begin
        for (int b = 0; b < N_CTRL; b++) begin
          if (!found && cnt[2*b+1] < TOP) begin
            lead = b;
            found = 1'b1;
          end
        end
        if (found) begin
          move[lead] = 1'b1;
          c = lead + 1;
          // The follower joins only in the same group phase as the leader.
          if (c < N_CTRL && cnt[2*lead+1] >= OVL && cnt[2*c+1] < TOP &&
              ((cnt[2*lead] == cnt[2*lead+1]) == (cnt[2*c] == cnt[2*c+1]))) begin
            move[c] = 1'b1;
          end
        end
        if (sel_q == rbo_pkg::SEL_AUTO && cnt[2*N_CTRL-1] > DLIM) begin
          move = '0;
        end
      end else if (in_q) begin
        for (int b = N_CTRL - 1; b >= 0; b--) begin
          if (!found && cnt[2*b+1] > POS_W'(0)) begin
            lead = b;
            found = 1'b1;
          end
        end
        if (found) begin
          move[lead] = 1'b1;
          c = lead - 1;
          if (c >= 0 && cnt[2*lead+1] <= JOIN_IN && cnt[2*c+1] > POS_W'(0) &&
              ((cnt[2*lead] == cnt[2*lead+1]) == (cnt[2*c] == cnt[2*c+1]))) begin
            move[c] = 1'b1;
          end
        end
      end
    end else begin
      // Individual bank, the only way a shutdown bank moves.
      c = int'(sel_q) - int'(rbo_pkg::SEL_BANK0);
      if (c >= 0 && c < NB) begin
        if ((out_q && cnt[2*c+1] < TOP) || (in_q && cnt[2*c+1] > POS_W'(0))) begin
          move[c] = 1'b1;
        end
      end
    end
    // Equal groups step group 1 next, otherwise group 2 catches up.
    for (int b = 0; b < NB; b++) begin
      grp[2*b] = move[b] && (cnt[2*b] == cnt[2*b+1]);
      grp[2*b+1] = move[b] && (cnt[2*b] != cnt[2*b+1]);
    end
  end

  // The pulser looks one increment ahead, so starts come one rounded-up minute-per-rate apart.
  logic wd_block, demand, ready, go;
  logic [6:0] rate;
  always_comb begin
    wd_block = |inh_s;
    if (sel_q == rbo_pkg::SEL_AUTO) begin
      if (spm_s < rbo_pkg::AUTO_MIN_SPM) begin
        rate = rbo_pkg::AUTO_MIN_SPM;
      end else if (spm_s > rbo_pkg::AUTO_MAX_SPM) begin
        rate = rbo_pkg::AUTO_MAX_SPM;
      end else begin
        rate = spm_s;
      end
    end else if (int'(sel_q) >= int'(rbo_pkg::SEL_BANK0) + N_CTRL) begin
      rate = MAN_SD_SPM;
    end else begin
      rate = MAN_CTRL_SPM;
    end
    demand = (|move) && (in_q || (out_q && !wd_block)) && !mux_s;
    ready = (acc + {25'h0, rate}) >= MIN_ACC;
    go = demand && ready && (cmd_raw == cmd_q);
  end

  // Next values for pulser, latch, cycler and counters.
  always_comb begin
    next_state = state;
    next_cmd_q = cmd_q;
    next_seq_cnt = seq_cnt;
    next_grp_q = grp_q;
    next_dir_q = dir_q;
    next_cnt = cnt;
    // The accumulator saturates, so speed only shapes the idle gap.
    next_acc = go ? 32'h0 : (ready ? acc : acc + {25'h0, rate});
    case (state)
      rbo_pkg::CYC_IDLE: begin
        next_cmd_q = cmd_raw;
        if (go) begin
          next_state = rbo_pkg::CYC_STEP;
          next_seq_cnt = SEQ_W'(SEQ_CYC - 1);
          next_grp_q = grp;
          next_dir_q = out_q;
        end
      end
      rbo_pkg::CYC_STEP: begin
        next_seq_cnt = seq_cnt - SEQ_W'(1);
        if (seq_cnt == SEQ_W'(0)) begin
          next_state = rbo_pkg::CYC_IDLE;
          next_grp_q = '0;
          for (int g = 0; g < NG; g++) begin
            if (grp_q[g]) begin
              next_cnt[g] = dir_q ? cnt[g] + POS_W'(1) : cnt[g] - POS_W'(1);
            end
          end
        end
        if (go) begin
          next_state = rbo_pkg::CYC_HALT;
          next_grp_q = '0;
        end
      end
      rbo_pkg::CYC_HALT: begin
        if (clr_s) begin
          next_state = rbo_pkg::CYC_IDLE;
        end
      end
      default: begin
        next_state = rbo_pkg::CYC_IDLE;
        next_grp_q = '0;
      end
    endcase
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      state <= rbo_pkg::CYC_IDLE;
      cmd_q <= '0;
      acc <= 32'h0;
      seq_cnt <= '0;
      grp_q <= '0;
      dir_q <= 1'b0;
      cnt <= '{default: POS_W'(rbo_pkg::POS_RESET)};
    end else begin
      state <= next_state;
      cmd_q <= next_cmd_q;
      acc <= next_acc;
      seq_cnt <= next_seq_cnt;
      grp_q <= next_grp_q;
      dir_q <= next_dir_q;
      cnt <= next_cnt;
    end
  end

  assign o_step_group = grp_q;
  assign o_dir_out = dir_q;
  assign o_busy = (state == rbo_pkg::CYC_STEP);
  assign o_urgent = (state == rbo_pkg::CYC_HALT);
  assign o_auto_active = auto_sel && auto_ok;
  assign o_withdraw_block = wd_block;
  assign o_cmd_pending = (cmd_raw != cmd_q);

  genvar gi;
  for (gi = 0; gi < NG; gi++) begin : g_pos
    assign o_group_pos[gi*POS_W +: POS_W] = cnt[gi];
  end

  // Helper: length of the running coil sequence.
  logic [31:0] run_len, next_run_len;
  always_comb begin
    next_run_len = o_busy ? run_len + 32'h1 : 32'h0;
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      run_len <= 32'h0;
    end else begin
      run_len <= next_run_len;
    end
  end

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);

  sequence s_start;
    state == rbo_pkg::CYC_IDLE && go;
  endsequence
  sequence s_halted;
    o_urgent && o_step_group == '0;
  endsequence

  a_seq_length: assert property ($fell(o_busy) && !o_urgent |-> run_len == 32'(SEQ_CYC))
    else $error("coil sequence length wrong");
  a_withdraw_block: assert property (s_start |-> !(out_q && wd_block)) else $error("withdraw while inhibited");
  a_mux_stop: assert property (mux_s |-> !go) else $error("step issued during multiplexing failure");
  a_auto_power: assert property (!(turb_s && therm_s) |-> !o_auto_active)
    else $error("automatic active at low power");
  a_early_halt: assert property (o_busy && go |=> s_halted ##1 (o_urgent || $past(clr_s)))
    else $error("early pulse did not halt");
  a_cmd_held: assert property (o_busy |=> $stable(cmd_q)) else $error("command changed during step");
  a_auto_limit: assert property (s_start and (sel_q == rbo_pkg::SEL_AUTO && out_q)
                                 |-> cnt[2*N_CTRL-1] <= DLIM)
    else $error("automatic withdrawal past bank D limit");
  a_rate_range: assert property (sel_q == rbo_pkg::SEL_AUTO |->
                                 rate >= rbo_pkg::AUTO_MIN_SPM && rate <= rbo_pkg::AUTO_MAX_SPM)
    else $error("automatic rate out of range");
  a_lever_hold: assert property (s_start |-> out_q != in_q) else $error("step started with no direction");

  generate
    for (gi = 0; gi < NB; gi++) begin : g_chk
      a_pair_close: assert property ((cnt[2*gi] - cnt[2*gi+1] <= POS_W'(1)) ||
                                     (cnt[2*gi+1] - cnt[2*gi] <= POS_W'(1)))
        else $error("groups of a bank apart");
      a_one_group: assert property (!(o_step_group[2*gi] && o_step_group[2*gi+1]))
        else $error("both groups of a bank stepping");
      if (gi > 0 && gi < N_CTRL) begin : g_ord
        a_bank_order: assert property (s_start and (out_q && move[gi] && sel_q <= rbo_pkg::SEL_MANUAL)
                                       |-> cnt[2*gi-1] >= OVL)
          else $error("bank withdrawn before predecessor overlap");
      end
      if (gi >= N_CTRL) begin : g_sd
        a_sd_manual: assert property (s_start and move[gi] |->
                                      int'(sel_q) == int'(rbo_pkg::SEL_BANK0) + gi)
          else $error("shutdown bank moved without selection");
      end
    end
  endgenerate

endmodule

`default_nettype wire

// >>> pkg/rbo_pkg.sv
/*
  Shared constants for the rod bank overlap sequencer: clock rate, coil
  sequence time, stepping rates, bank geometry, selector codes and states.
  Assumes a single 10 MHz system clock.
*/
`default_nettype none

package rbo_pkg;

  // System clock and the fixed coil sequence.
  localparam int CLK_HZ = 10_000_000;
  localparam int SEQ_MS = 780;
  localparam int SEQ_CYC = SEQ_MS * (CLK_HZ / 1000);
  localparam int MINUTE_S = 60;
  localparam int MINUTE_CYC = MINUTE_S * CLK_HZ;

  // Stepping rates in steps per minute.
  localparam int SPM_W = 7;
  localparam logic [6:0] AUTO_MIN_SPM = 7'h08;
  localparam logic [6:0] AUTO_MAX_SPM = 7'h48;
  localparam logic [6:0] MAN_CTRL_SPM = 7'h30;
  localparam logic [6:0] MAN_SD_SPM = 7'h40;

  // Bank geometry, positions in steps.
  localparam int N_CTRL = 4;
  localparam int N_SD = 2;
  localparam int POS_W = 8;
  localparam logic [7:0] TOP_STEPS = 8'he4;
  localparam logic [7:0] OVERLAP_STEPS = 8'h80;
  localparam logic [7:0] D_LIMIT_STEPS = 8'hdc;
  localparam logic [7:0] POS_RESET = 8'h00;

  // Bank selector codes; individual banks follow from SEL_BANK0 upward.
  localparam int SEL_W = 3;
  localparam logic [2:0] SEL_AUTO = 3'h0;
  localparam logic [2:0] SEL_MANUAL = 3'h1;
  localparam logic [2:0] SEL_BANK0 = 3'h2;

  typedef enum logic [1:0] {
    CYC_IDLE,
    CYC_STEP,
    CYC_HALT
  } rbo_cyc_t;

endpackage

`default_nettype wire

// >>> testbench/rbo_operator_model.sv
/*
  Operator panel and automatic speed demand facing the sequencer.
  Assumes the bench calls its tasks; pins change only at falling edges.
*/
`default_nettype none

module rbo_operator_model (
  input wire logic i_clk, // System clock.
  output logic [rbo_pkg::SEL_W-1:0] o_selector, // Bank selector.
  output logic o_lever_in, // Lever in.
  output logic o_lever_out, // Lever out.
  output logic o_auto_in, // Automatic insert demand.
  output logic o_auto_out, // Automatic withdraw demand.
  output logic [rbo_pkg::SPM_W-1:0] o_auto_spm // Automatic speed demand.
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    o_selector = 3'h1;
    o_lever_in = 1'b0;
    o_lever_out = 1'b0;
    o_auto_in = 1'b0;
    o_auto_out = 1'b0;
    o_auto_spm = 7'h08;
  end

  // A three-position switch, so in and out are never high together.
  task automatic manual(input logic [2:0] sel, input logic [1:0] lev);
    @(negedge i_clk);
    o_selector = sel;
    o_lever_in = lev[0];
    o_lever_out = lev[1];
  endtask

  task automatic auto(input logic [1:0] dem, input logic [6:0] spm);
    @(negedge i_clk);
    o_auto_in = dem[0];
    o_auto_out = dem[1];
    o_auto_spm = spm;
  endtask
endmodule

`default_nettype wire

// >>> testbench/rbo_sequencer_tb.sv
/*
  Self-checking bench for the rod bank overlap sequencer.
  Assumes shortened counts; a second instance with a short minute is
  driven too fast on purpose to reach the overspeed halt.
*/
`default_nettype none

module rbo_sequencer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SEQ = 20;
  localparam logic [7:0] TOP = 8'h0c;
  localparam logic [7:0] OVL = 8'h06;
  localparam logic [7:0] DLIM = 8'h0a;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [2:0] sel;
  logic lin, lout, ain, aout;
  logic [6:0] spm;
  logic [3:0] inh = 4'h0;
  logic tok = 1'b1;
  logic hok = 1'b1;
  logic mux = 1'b0;
  logic fclr = 1'b0;
  logic [11:0] grp, grp2, m;
  logic dir, busy, urg, urg2, act, wblk, pend;
  logic [95:0] gpos;
  logic [95:0] epos = 96'h0;
  logic [2:0] esel = 3'h1;
  logic edir = 1'b1;
  logic pb = 1'b0;
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;
  int starts = 0;
  int last = 0;
  int gap = 0;

  always #50 clk = ~clk;

  rbo_operator_model op (.i_clk(clk), .o_selector(sel), .o_lever_in(lin), .o_lever_out(lout),
    .o_auto_in(ain), .o_auto_out(aout), .o_auto_spm(spm));
  rbo_sequencer #(.SEQ_CYC(SEQ), .MINUTE_CYC(1500), .TOP(TOP), .OVL(OVL), .DLIM(DLIM)) rbo_sequencer_i (
    .i_clk(clk), .i_reset(rst), .i_selector(sel), .i_lever_in(lin), .i_lever_out(lout), .i_auto_in(ain),
    .i_auto_out(aout), .i_auto_spm(spm), .i_pr_overpower(inh[0]), .i_ir_overpower(inh[1]),
    .i_op_delta_t(inh[2]), .i_ot_delta_t(inh[3]), .i_turbine_ok(tok), .i_thermal_ok(hok),
    .i_mux_fail(mux), .i_fault_clear(fclr), .o_step_group(grp), .o_dir_out(dir), .o_busy(busy),
    .o_urgent(urg), .o_auto_active(act), .o_withdraw_block(wblk), .o_cmd_pending(pend), .o_group_pos(gpos));
  // A short minute makes 72 steps per minute faster than one coil sequence.
  rbo_sequencer #(.SEQ_CYC(SEQ), .MINUTE_CYC(1000), .TOP(TOP), .OVL(OVL), .DLIM(DLIM)) rbo_sequencer_fast_i (
    .i_clk(clk), .i_reset(rst), .i_selector(sel), .i_lever_in(lin), .i_lever_out(lout), .i_auto_in(ain),
    .i_auto_out(aout), .i_auto_spm(spm), .i_pr_overpower(inh[0]), .i_ir_overpower(inh[1]),
    .i_op_delta_t(inh[2]), .i_ot_delta_t(inh[3]), .i_turbine_ok(tok), .i_thermal_ok(hok),
    .i_mux_fail(mux), .i_fault_clear(fclr), .o_step_group(grp2), .o_dir_out(), .o_busy(),
    .o_urgent(urg2), .o_auto_active(), .o_withdraw_block(), .o_cmd_pending(), .o_group_pos());

  task automatic check(input string name, input logic [95:0] seen, input logic [95:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  function automatic logic [7:0] g2(input int b);
    return epos[16*b+8 +: 8];
  endfunction

  function automatic logic ph(input int b);
    return epos[16*b +: 8] == g2(b);
  endfunction

  // Group 1 moves when the bank's groups are level, otherwise group 2 catches up.
  function automatic logic [11:0] bit1(input int b);
    return ph(b) ? 12'h001 << (2 * b) : 12'h002 << (2 * b);
  endfunction

  function automatic logic [11:0] emask();
    int l;
    logic [11:0] r;
    r = 12'h000;
    if (esel >= 3'h2) return bit1(int'(esel) - 2);
    l = edir ? 0 : 3;
    while (l >= 0 && l < 4 && (edir ? g2(l) == TOP : g2(l) == 8'h00)) l = edir ? l + 1 : l - 1;
    if (l < 0 || l > 3) return r;
    r = bit1(l);
    if (edir && l < 3 && g2(l) >= OVL && ph(l) == ph(l + 1)) r |= bit1(l + 1);
    if (!edir && l > 0 && g2(l) <= TOP - OVL && ph(l) == ph(l - 1)) r |= bit1(l - 1);
    return r;
  endfunction

  always @(negedge clk) begin
    cyc++;
    if (busy === 1'b1 && pb !== 1'b1) begin
      m = emask();
      check("step_group", 96'(grp), 96'(m));
      check("dir_out", 96'(dir), 96'(edir));
      gap = cyc - last;
      last = cyc;
      starts++;
      for (int k = 0; k < 12; k++) if (m[k]) epos[8*k +: 8] = edir ? epos[8*k +: 8] + 8'h01 : epos[8*k +: 8] - 8'h01;
    end
    if (busy !== 1'b1 && pb === 1'b1) begin
      check("busy_len", 96'(cyc - last), 96'(SEQ));
      check("group_pos", gpos, epos);
    end
    pb = busy;
  end

  task automatic steps(input int n);
    int s0;
    s0 = starts;
    repeat (250 * n) if (starts < s0 + n) @(negedge clk);
    check("steps", 96'(starts - s0), 96'(n));
  endtask

  task automatic idle(input int n, input string name);
    int s0;
    s0 = starts;
    repeat (n) @(negedge clk);
    check(name, 96'(starts - s0), 96'h0);
  endtask

  task automatic rate(input int lo, input string name);
    check(name, 96'(gap >= lo && gap <= lo + 1), 96'h1);
  endtask

  task automatic fin(input string t);
    $display("test %s done", t);
  endtask

  initial begin
    repeat (16) @(negedge clk);
    check("reset_pos", gpos, 96'h0);
    check("reset_out", 96'({grp, dir, busy, urg, act, wblk, pend}), 96'h0);
    rst = 1'b0;
    op.manual(3'h0, 2'b10);
    idle(100, "lever_in_auto");
    for (int s = 1; s < 8; s++) begin
      op.manual(3'(s), 2'b00);
      idle(40, "hold_select");
    end
    fin("hold");
    op.manual(3'h1, 2'b10);
    for (int i = 0; i < 4; i++) begin
      inh = 4'h1 << i;
      idle(80, "inhibit");
      check("withdraw_block", 96'(wblk), 96'h1);
    end
    inh = 4'h0;
    steps(24);
    rate(31, "rate_manual");
    fin("manual_out");
    op.manual(3'h6, 2'b10);
    esel = 3'h6;
    repeat (3) @(negedge clk);
    check("cmd_pending", 96'(pend), 96'h1);
    steps(4);
    rate(23, "rate_shutdown");
    fin("pending_shutdown");
    op.manual(3'h1, 2'b01);
    esel = 3'h1;
    edir = 1'b0;
    steps(4);
    mux = 1'b1;
    idle(100, "mux_fail");
    fin("insert_mux");
    esel = 3'h0;
    edir = 1'b1;
    tok = 1'b0;
    op.manual(3'h0, 2'b01);
    op.auto(2'b10, 7'h64);
    mux = 1'b0;
    idle(100, "turbine_low");
    check("auto_active", 96'(act), 96'h0);
    tok = 1'b1;
    hok = 1'b0;
    idle(100, "thermal_low");
    check("auto_active", 96'(act), 96'h0);
    hok = 1'b1;
    steps(3);
    check("auto_active", 96'(act), 96'h1);
    rate(20, "rate_clamp_high");
    op.auto(2'b10, 7'h03);
    steps(2);
    rate(187, "rate_clamp_low");
    fclr = 1'b1;
    repeat (4) @(negedge clk);
    fclr = 1'b0;
    op.auto(2'b10, 7'h48);
    begin
      int q;
      q = 0;
      repeat (4000) if (q < 300) begin
        @(negedge clk);
        q = busy === 1'b1 ? 0 : q + 1;
      end
    end
    check("bank_d_limit", 96'(gpos[63:56]), 96'(DLIM + 8'h01));
    check("bank_c_top", 96'(gpos[47:40]), 96'(TOP));
    check("fast_urgent", 96'(urg2), 96'h1);
    check("fast_orders", 96'(grp2), 96'h0);
    fclr = 1'b1;
    repeat (4) @(negedge clk);
    fclr = 1'b0;
    repeat (3) @(negedge clk);
    check("fast_cleared", 96'(urg2), 96'h0);
    fin("auto");
    check("urgent", 96'(urg), 96'h0);
    op.manual(3'h5, 2'b10);
    esel = 3'h5;
    steps(2);
    op.manual(3'h7, 2'b10);
    esel = 3'h7;
    steps(2);
    rate(23, "rate_shutdown_b");
    fin("individual");
    conclude();
  end

  // Planned traffic needs under 10000 cycles; this allows three times that.
  initial begin
    #3000000;
    num_errors++;
    conclude();
  end
endmodule

`default_nettype wire
